//--- hw/t2ctl_pkg.sv
package t2ctl_pkg;

  // ==========================================================
  // Register offsets on the plain register port
  localparam logic [3:0] T2CTL_ADDR_CTRL = 4'h0;
  localparam logic [3:0] T2CTL_ADDR_MODE = 4'h1;
  localparam logic [3:0] T2CTL_ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] T2CTL_ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] T2CTL_ADDR_RLD_LO = 4'h4;
  localparam logic [3:0] T2CTL_ADDR_RLD_HI = 4'h5;
  localparam logic [3:0] T2CTL_ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] T2CTL_ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] T2CTL_ADDR_IRQ_CLR = 4'h8;

  // ==========================================================
  // Field positions
  localparam int T2CTL_MODE_UPDN_BIT = 0;
  localparam int T2CTL_IRQ_OVF_BIT = 0;
  localparam int T2CTL_IRQ_EXT_BIT = 1;
  localparam int T2CTL_IRQ_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] T2CTL_CTRL_RST = 8'h00;
  localparam logic [7:0] T2CTL_MODE_RST = 8'h00;
  localparam logic [15:0] T2CTL_CNT_RST = 16'h0000;
  localparam logic [15:0] T2CTL_RLD_RST = 16'h0000;
  localparam logic [1:0] T2CTL_IRQ_RST = 2'h0;

  // ==========================================================
  // Timing counts: core clocks per count step
  localparam logic [3:0] T2CTL_DIV_TIMER = 4'hc;
  localparam logic [3:0] T2CTL_DIV_BAUD = 4'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic source_select;
    logic capture_reload_select;
  } t2ctl_ctrl_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t2ctl_bus_t;

endpackage : t2ctl_pkg

//--- hw/t2ctl_fall.sv
`timescale 1ns/1ps
// ==========================================================
// Falling edge detector for synchronous pins
module t2ctl_fall (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Pin and edge
  input wire logic sig_in,
  output logic fall_out
);

  logic prev_q;

  // Reset low so a pin held low at start makes no edge
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_q <= 1'b0;
    end else if (ce_in) begin
      prev_q <= sig_in;
    end
  end

  assign fall_out = ce_in & prev_q & ~sig_in;

endmodule : t2ctl_fall

//--- hw/t2ctl_count.sv
`timescale 1ns/1ps
// ==========================================================
// 16-bit up/down counter with reload and wrap detect
module t2ctl_count
  import t2ctl_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Control
  input wire logic tick_in,
  input wire logic up_in,
  input wire logic reload_on_wrap_in,
  input wire logic hw_reload_in,
  input wire logic [WIDTH-1:0] reload_val_in,
  // Software access
  input wire logic sw_wr_in,
  input wire logic [WIDTH-1:0] sw_val_in,
  // Results
  output logic [WIDTH-1:0] count_out,
  output logic wrap_out
);

  logic [WIDTH-1:0] cnt_q;
  logic top;
  logic bottom;

  // Up wraps past all ones, down wraps on reaching the reload value
  assign top = (cnt_q == {WIDTH{1'b1}});
  assign bottom = (cnt_q == reload_val_in);
  assign wrap_out = ce_in & tick_in & ~sw_wr_in & (up_in ? top : bottom);
  assign count_out = cnt_q;

  // Software write wins over counting so a load is never lost
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= WIDTH'(T2CTL_CNT_RST);
    end else if (ce_in) begin
      if (sw_wr_in) begin
        cnt_q <= sw_val_in;
      end else if (hw_reload_in) begin
        cnt_q <= reload_val_in;
      end else if (tick_in) begin
        if (up_in) begin
          if (top) begin
            cnt_q <= reload_on_wrap_in ? reload_val_in : '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else if (bottom) begin
          cnt_q <= {WIDTH{1'b1}};
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule : t2ctl_count

//--- hw/t2ctl_top.sv
// How it works
// - Trigger edge causing capture/reload sets external flag
// - External flag raises the shared timer request
// - Only software or an up/down wrap toggle clears the external flag
// - Up/down mode blocks external flag request
// - Receive clock select picks timer or Timer 1
// - Transmit clock select picks timer or Timer 1
// - Trigger reloads or captures only outside baud generator mode
// - Trigger enable clear ignores trigger pin outside up/down mode
// - Source select: prescaled clock or event edges
// - Counter overflow sets the overflow flag
// - Baud mode rollover sets no flag, no request
// - Run control gates all counting
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module t2ctl_top
  import t2ctl_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Register port
  input wire t2ctl_bus_t bus_in,
  output logic [7:0] rdata_out,
  // Pins and serial port side
  input wire logic external_trigger_input_in,
  input wire logic event_count_in,
  input wire logic t1_overflow_in,
  input wire logic [1:0] serial_mode_in,
  output logic rx_baud_tick_out,
  output logic tx_baud_tick_out,
  // Requests
  output logic timer_req_out,
  output logic irq_out
);

  // ==========================================================
  // Storage
  // Both flags live in the control register itself
  t2ctl_ctrl_t ctrl_q;
  logic [7:0] mode_q;
  logic [WIDTH-1:0] rld_q;
  logic [T2CTL_IRQ_W-1:0] irq_stat_q;
  logic [T2CTL_IRQ_W-1:0] irq_en_q;
  logic [3:0] presc_q;
  logic [7:0] rdata_q;
  logic rx_tick_q;
  logic tx_tick_q;

  // ==========================================================
  // Bus decode
  // Offsets beyond the map decode to no register
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_irq_en;
  logic wr_irq_clr;
  t2ctl_ctrl_t wctrl;

  // Single write strobe qualified per offset
  function automatic logic hit(input logic [3:0] a);
    hit = bus_in.wr & (bus_in.addr == a);
  endfunction : hit

  assign wr_ctrl = hit(T2CTL_ADDR_CTRL);
  assign wr_mode = hit(T2CTL_ADDR_MODE);
  assign wr_cnt_lo = hit(T2CTL_ADDR_CNT_LO);
  assign wr_cnt_hi = hit(T2CTL_ADDR_CNT_HI);
  assign wr_rld_lo = hit(T2CTL_ADDR_RLD_LO);
  assign wr_rld_hi = hit(T2CTL_ADDR_RLD_HI);
  assign wr_irq_en = hit(T2CTL_ADDR_IRQ_EN);
  assign wr_irq_clr = hit(T2CTL_ADDR_IRQ_CLR);
  // Written control byte seen field by field
  assign wctrl = t2ctl_ctrl_t'(bus_in.wdata);

  // ==========================================================
  // Operating mode
  logic baud_mode;
  logic capture_mode;
  logic updn_en;
  logic updn_mode;

  // Either serial select forces auto-reload and baud timing
  assign baud_mode = ctrl_q.receive_clock_select |
                     ctrl_q.transmit_clock_select;
  assign capture_mode = ctrl_q.capture_reload_select & ~baud_mode;
  // Capture or baud timing overrides the up/down option
  assign updn_en = mode_q[T2CTL_MODE_UPDN_BIT];
  assign updn_mode = updn_en & ~capture_mode & ~baud_mode;

  // ==========================================================
  // Pin edges
  // Pins are taken as synchronous; no filtering here
  logic trig_fall;
  logic event_fall;

  t2ctl_fall u_trig_fall (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .sig_in(external_trigger_input_in),
    .fall_out(trig_fall)
  );

  t2ctl_fall u_event_fall (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .sig_in(event_count_in),
    .fall_out(event_fall)
  );

  // ==========================================================
  // Trigger events
  logic trig;
  logic cap_evt;
  logic rld_evt;
  logic ext_set;

  // In up/down mode the trigger pin steers direction instead
  assign trig = trig_fall & ctrl_q.external_trigger_enable & ~updn_mode;
  assign cap_evt = trig & capture_mode;
  assign rld_evt = trig & ~capture_mode & ~baud_mode;
  // Baud mode keeps the flag so the pin still works as an interrupt
  assign ext_set = cap_evt | rld_evt | (trig & baud_mode);

  // ==========================================================
  // Count step generation
  // Limitation: event pin must stay low a full cycle
  logic [3:0] div;
  logic presc_hit;
  logic tick;

  // Baud mode steps every two clocks, timer mode every twelve
  assign div = baud_mode ? T2CTL_DIV_BAUD : T2CTL_DIV_TIMER;
  assign presc_hit = (presc_q == 4'(div - 4'h1));
  assign tick = ctrl_q.run_control &
                (ctrl_q.source_select ? event_fall : presc_hit);

  // Prescaler restarts while stopped for a clean first step
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      presc_q <= 4'h0;
    end else if (ce_in) begin
      if (!ctrl_q.run_control || presc_hit) begin
        presc_q <= 4'h0;
      end else begin
        presc_q <= presc_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Counter
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] cnt_wval;
  logic wrap;
  logic ovf_set;

  // Byte writes merge into the live count
  assign cnt_wval = wr_cnt_lo ? {count[WIDTH-1:8], bus_in.wdata} :
                                {bus_in.wdata, count[7:0]};

  // Direction pin only matters in up/down mode
  t2ctl_count #(
    .WIDTH(WIDTH)
  ) u_count (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .up_in(~updn_mode | external_trigger_input_in),
    .reload_on_wrap_in(~capture_mode),
    .hw_reload_in(rld_evt),
    .reload_val_in(rld_q),
    .sw_wr_in(wr_cnt_lo | wr_cnt_hi),
    .sw_val_in(cnt_wval),
    .count_out(count),
    .wrap_out(wrap)
  );

  assign ovf_set = wrap & ~baud_mode;

  // ==========================================================
  // Reload / capture register
  // Capture beats a software write in the same cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rld_q <= WIDTH'(T2CTL_RLD_RST);
    end else if (ce_in) begin
      if (cap_evt) begin
        rld_q <= count;
      end else if (wr_rld_lo) begin
        rld_q[7:0] <= bus_in.wdata;
      end else if (wr_rld_hi) begin
        rld_q[WIDTH-1:8] <= bus_in.wdata[WIDTH-9:0];
      end
    end
  end

  // ==========================================================
  // Control register and flags
  logic ovf_base;
  logic ext_base;

  // Software may write either flag; hardware setting wins
  assign ovf_base = wr_ctrl ? wctrl.overflow_flag : ctrl_q.overflow_flag;
  assign ext_base = wr_ctrl ? wctrl.external_flag : ctrl_q.external_flag;

  // Other bits change only on a control write
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= t2ctl_ctrl_t'(T2CTL_CTRL_RST);
    end else if (ce_in) begin
      if (wr_ctrl) begin
        ctrl_q.receive_clock_select <= wctrl.receive_clock_select;
        ctrl_q.transmit_clock_select <= wctrl.transmit_clock_select;
        ctrl_q.external_trigger_enable <= wctrl.external_trigger_enable;
        ctrl_q.run_control <= wctrl.run_control;
        ctrl_q.source_select <= wctrl.source_select;
        ctrl_q.capture_reload_select <= wctrl.capture_reload_select;
      end
      ctrl_q.overflow_flag <= ovf_base | ovf_set;
      // Up/down wrap toggles the flag as a seventeenth count bit
      if (ext_set) begin
        ctrl_q.external_flag <= 1'b1;
      end else if (wrap && updn_mode) begin
        ctrl_q.external_flag <= ~ext_base;
      end else begin
        ctrl_q.external_flag <= ext_base;
      end
    end
  end

  // ==========================================================
  // Mode register
  // Only the direction enable bit is stored; rest reads 0
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= T2CTL_MODE_RST;
    end else if (ce_in && wr_mode) begin
      mode_q <= {7'h00, bus_in.wdata[T2CTL_MODE_UPDN_BIT]};
    end
  end

  // ==========================================================
  // Timer request to the interrupt controller
  // Shared vector: overflow flag, or external flag with up/down enable clear, raises one request line
  assign timer_req_out = ctrl_q.overflow_flag |
                         (ctrl_q.external_flag & ~updn_en);

  // ==========================================================
  // Sticky event status, enable and write-one clear
  logic [T2CTL_IRQ_W-1:0] irq_set;

  // Hardware events only; flag writes by software set none
  always_comb begin
    irq_set = '0;
    irq_set[T2CTL_IRQ_OVF_BIT] = ovf_set;
    irq_set[T2CTL_IRQ_EXT_BIT] = ext_set & ~updn_en;
  end

  // A new event in the clearing cycle stays set
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat_q <= T2CTL_IRQ_RST;
    end else if (ce_in) begin
      irq_stat_q <= (irq_stat_q &
                     ~(wr_irq_clr ? bus_in.wdata[T2CTL_IRQ_W-1:0] : '0)) |
                    irq_set;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_en_q <= T2CTL_IRQ_RST;
    end else if (ce_in && wr_irq_en) begin
      irq_en_q <= bus_in.wdata[T2CTL_IRQ_W-1:0];
    end
  end

  // Level output, held until status is cleared or masked
  assign irq_out = |(irq_stat_q & irq_en_q);

  // ==========================================================
  // Serial port baud ticks
  logic serial_13;

  // Only serial modes 1 and 3 take a timer rate
  assign serial_13 = serial_mode_in[0];

  // One cycle late, so the serial port sees a clean pulse
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else if (ce_in) begin
      rx_tick_q <= (ctrl_q.receive_clock_select && serial_13) ?
                   wrap : t1_overflow_in;
      tx_tick_q <= (ctrl_q.transmit_clock_select && serial_13) ?
                   wrap : t1_overflow_in;
    end
  end

  assign rx_baud_tick_out = rx_tick_q;
  assign tx_baud_tick_out = tx_tick_q;

  // ==========================================================
  // Read data, one cycle after the strobe, zero elsewhere
  logic [7:0] rd_mux;

  // Write-only clear and unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_in.addr)
      T2CTL_ADDR_CTRL: rd_mux = 8'(ctrl_q);
      T2CTL_ADDR_MODE: rd_mux = mode_q;
      T2CTL_ADDR_CNT_LO: rd_mux = count[7:0];
      T2CTL_ADDR_CNT_HI: rd_mux = count[WIDTH-1:8];
      T2CTL_ADDR_RLD_LO: rd_mux = rld_q[7:0];
      T2CTL_ADDR_RLD_HI: rd_mux = rld_q[WIDTH-1:8];
      T2CTL_ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      T2CTL_ADDR_IRQ_EN: rd_mux = {6'h00, irq_en_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (ce_in) begin
      rdata_q <= bus_in.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata_out = rdata_q;

endmodule : t2ctl_top

//--- tb/t2ctl_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks for the timer control block
module t2ctl_properties
  import t2ctl_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Register port
  input wire t2ctl_bus_t bus_in,
  input wire logic [7:0] rdata_out,
  // Pins and serial side
  input wire logic external_trigger_input_in,
  input wire logic t1_overflow_in,
  input wire logic [1:0] serial_mode_in,
  input wire logic rx_baud_tick_out,
  input wire logic tx_baud_tick_out,
  // Requests
  input wire logic timer_req_out,
  input wire logic irq_out
);
  logic [5:0] ctl_q;
  logic updn_q;
  logic [1:0] quiet_q;
  logic wr_ok;
  logic quiet;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  assign wr_ok = bus_in.wr && ce_in;
  assign quiet = (quiet_q == 2'h3);
  // Shadow of software-only bits; hardware never alters them
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_q <= 6'h00;
      updn_q <= 1'b0;
    end else if (wr_ok && bus_in.addr == T2CTL_ADDR_CTRL) begin
      ctl_q <= bus_in.wdata[5:0];
    end else if (wr_ok && bus_in.addr == T2CTL_ADDR_MODE) begin
      updn_q <= bus_in.wdata[0];
    end
  end
  // Cycles since last write; masks steps already in flight
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      quiet_q <= 2'h0;
    end else if (wr_ok) begin
      quiet_q <= 2'h0;
    end else if (!quiet) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end

  AST_RDATA_IDLE: assert property (
    !$past(bus_in.rd && ce_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  AST_RD_CTRL: assert property (
    $past(bus_in.rd && ce_in && bus_in.addr == T2CTL_ADDR_CTRL)
    |-> rdata_out[5:0] == $past(ctl_q))
    else $error("control read back wrong");
  AST_RX_T1: assert property (
    !ctl_q[5] && serial_mode_in[0] && t1_overflow_in && quiet
    |=> rx_baud_tick_out)
    else $error("rx tick missed timer 1");
  AST_TX_T1: assert property (
    !ctl_q[4] && serial_mode_in[0] && t1_overflow_in && quiet
    |=> tx_baud_tick_out)
    else $error("tx tick missed timer 1");
  AST_REQ_FALL: assert property (
    $fell(timer_req_out) |-> $past(wr_ok))
    else $error("request cleared without write");
  AST_IRQ_FALL: assert property (
    $fell(irq_out) |-> $past(wr_ok))
    else $error("irq cleared without write");
  AST_STOPPED: assert property (
    !ctl_q[2] && quiet && (!ctl_q[3] || updn_q) |=> !$rose(timer_req_out))
    else $error("request rose while idle");
  AST_BAUD_NOFLAG: assert property (
    (ctl_q[5] || ctl_q[4]) && !ctl_q[3] && quiet
    |=> !$rose(timer_req_out) && !$rose(irq_out))
    else $error("baud rollover raised flag");
  AST_TRIG_EXT: assert property (
    ctl_q[3] && !updn_q && quiet && $fell(external_trigger_input_in)
    |-> ##[1:2] timer_req_out)
    else $error("trigger edge set no flag");
endmodule : t2ctl_properties

//--- tb/t2ctl_pins_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: trigger pin, event pin, Timer 1 overflow
module t2ctl_pins_model #(
  parameter int T1_PER = 5
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Bench commands
  input wire logic trig_go_in,
  input wire logic ev_go_in,
  // Pins
  output logic trig_out,
  output logic ev_out,
  output logic t1_ovf_out
);
  logic [1:0] trig_q;
  logic [1:0] ev_q;
  int t1_q;
  // A command pulls its pin low for three cycles; idle is high
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trig_q <= 2'h0;
      ev_q <= 2'h0;
      t1_q <= 0;
    end else begin
      trig_q <= trig_go_in ? 2'h3 : trig_q - 2'(trig_q != 2'h0);
      ev_q <= ev_go_in ? 2'h3 : ev_q - 2'(ev_q != 2'h0);
      t1_q <= (t1_q == T1_PER - 1) ? 0 : t1_q + 1;
    end
  end
  // Outputs change only just after an edge
  assign trig_out = (trig_q == 2'h0);
  assign ev_out = (ev_q == 2'h0);
  assign t1_ovf_out = (t1_q == 0) && rstn_in;
endmodule : t2ctl_pins_model

//--- tb/t2ctl_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the timer control block
module t2ctl_tb
  import t2ctl_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  t2ctl_bus_t bus = 14'h0000;
  logic [7:0] rdata;
  logic [1:0] smode = 2'h0;
  logic trig_go = 1'b0;
  logic ev_go = 1'b0;
  logic trig, ev, t1, rx, tx, req, irq;
  int err_count = 0;
  int checks_done = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  t2ctl_top uut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .bus_in(bus), .rdata_out(rdata),
    .external_trigger_input_in(trig), .event_count_in(ev),
    .t1_overflow_in(t1), .serial_mode_in(smode),
    .rx_baud_tick_out(rx), .tx_baud_tick_out(tx),
    .timer_req_out(req), .irq_out(irq));
  t2ctl_pins_model pins (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .trig_go_in(trig_go),
    .ev_go_in(ev_go), .trig_out(trig), .ev_out(ev), .t1_ovf_out(t1));
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk_in);
    bus.wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk_in);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge ref_clk_in);
  endtask : rd
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    v = {hi, lo};
  endtask : rd16
  // One falling edge on the event or trigger pin
  task automatic pulse(input logic on_ev);
    ev_go <= on_ev;
    trig_go <= ~on_ev;
    @(posedge ref_clk_in);
    ev_go <= 1'b0;
    trig_go <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // Tests
  initial begin
    logic [15:0] r, v, x;
    logic [7:0] d;
    int n, m, k;
    void'($urandom(60));
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    // Reset values, one unmapped address too
    for (k = 0; k < 9; k++) begin
      rd(k == 8 ? 4'hf : 4'(k), d);
      chk({8'h00, d}, 16'h0000, "reset");
    end
    $display("reset test done");
    // Overflow from the prescaled clock, then held after stop
    wr(T2CTL_ADDR_IRQ_EN, 8'h03);
    wr16(T2CTL_ADDR_CNT_LO, 16'hfffe);
    wr(T2CTL_ADDR_CTRL, 8'h04);
    n = 0;
    while (req !== 1'b1 && n < 60) begin
      @(posedge ref_clk_in);
      n++;
    end
    m = 2 * int'(T2CTL_DIV_TIMER);
    chk(16'(n >= m - 6 && n <= m + 4), 16'h0001, "ovf time");
    chk({15'h0, irq}, 16'h0001, "irq");
    wr(T2CTL_ADDR_CTRL, 8'h80);
    rd16(T2CTL_ADDR_CNT_LO, r);
    repeat (40) @(posedge ref_clk_in);
    rd16(T2CTL_ADDR_CNT_LO, v);
    chk(v, r, "stopped");
    chk({15'h0, req}, 16'h0001, "ovf held");
    wr(T2CTL_ADDR_IRQ_CLR, 8'h01);
    chk({15'h0, irq}, 16'h0000, "irq clear");
    $display("overflow test done");
    // Counting falling edges of the event pin
    r = 16'($urandom % 32'hff00);
    k = 1 + $urandom % 6;
    wr16(T2CTL_ADDR_CNT_LO, r);
    wr(T2CTL_ADDR_CTRL, 8'h06);
    repeat (k) pulse(1'b1);
    // Edge while frozen by the clock enable must be lost
    ce_in <= 1'b0;
    pulse(1'b1);
    ce_in <= 1'b1;
    wr(T2CTL_ADDR_CTRL, 8'h00);
    rd16(T2CTL_ADDR_CNT_LO, v);
    chk(v, r + 16'(k), "events");
    chk({15'h0, req}, 16'h0000, "sw clear");
    $display("event test done");
    // Trigger edge: capture, reload, then ignored
    for (k = 0; k < 3; k++) begin
      r = 16'($urandom % 32'hff00);
      wr16(T2CTL_ADDR_RLD_LO, ~r);
      wr16(T2CTL_ADDR_CNT_LO, r);
      wr(T2CTL_ADDR_CTRL, k == 0 ? 8'h0f : (k == 1 ? 8'h0e : 8'h06));
      // Settle after the control write before the edge
      repeat (2) @(posedge ref_clk_in);
      pulse(1'b0);
      repeat (20) @(posedge ref_clk_in);
      rd(T2CTL_ADDR_CTRL, d);
      chk({15'h0, d[6]}, 16'(k < 2), "ext flag");
      rd16(T2CTL_ADDR_RLD_LO, x);
      chk(x, k == 0 ? r : ~r, "capture");
      rd16(T2CTL_ADDR_CNT_LO, x);
      chk(x, k == 1 ? ~r : r, "reload");
    end
    rd(T2CTL_ADDR_IRQ_STAT, d);
    chk({8'h00, d}, 16'h0002, "ext event");
    wr(T2CTL_ADDR_IRQ_CLR, 8'h02);
    $display("trigger test done");
    // Up/down mode hides the external flag from the request
    wr(T2CTL_ADDR_MODE, 8'h01);
    wr(T2CTL_ADDR_CTRL, 8'h40);
    chk({15'h0, req}, 16'h0000, "updn");
    wr(T2CTL_ADDR_MODE, 8'h00);
    chk({15'h0, req}, 16'h0001, "ext req");
    // Up/down wrap toggles the flag but raises no external event
    wr(T2CTL_ADDR_MODE, 8'h01);
    wr16(T2CTL_ADDR_CNT_LO, 16'hffff);
    wr(T2CTL_ADDR_CTRL, 8'h06);
    pulse(1'b1);
    rd(T2CTL_ADDR_CTRL, d);
    chk({14'h0, d[7:6]}, 16'h0003, "toggle");
    rd(T2CTL_ADDR_IRQ_STAT, d);
    chk({8'h00, d}, 16'h0001, "no ext event");
    wr(T2CTL_ADDR_MODE, 8'h00);
    $display("up down test done");
    // Baud ticks from this timer on one side, Timer 1 on other
    smode <= {1'($urandom), 1'b1};
    wr16(T2CTL_ADDR_RLD_LO, 16'hffff);
    wr16(T2CTL_ADDR_CNT_LO, 16'hffff);
    for (k = 0; k < 2; k++) begin
      wr(T2CTL_ADDR_CTRL, k == 0 ? 8'h14 : 8'h24);
      n = 0;
      m = 0;
      repeat (4) @(posedge ref_clk_in);
      repeat (40) begin
        @(negedge ref_clk_in);
        n += (k == 0 ? tx : rx);
        m += (k == 0 ? rx : tx);
      end
      @(posedge ref_clk_in);
      x = 16'(40 / int'(T2CTL_DIV_BAUD));
      chk(16'(n >= x - 1 && n <= x + 1), 16'h0001, "tmr");
      chk(16'(m >= 7 && m <= 9), 16'h0001, "t1 ticks");
      chk({15'h0, req}, 16'h0000, "baud flag");
    end
    wr(T2CTL_ADDR_CTRL, 8'h00);
    $display("baud test done");
    end_sim();
  end
  // Hang guard well beyond the few hundred cycles the tests need
  initial begin
    repeat (8000) @(posedge ref_clk_in);
    err_count++;
    end_sim();
  end
endmodule : t2ctl_tb

bind t2ctl_top t2ctl_properties #(.WIDTH(WIDTH)) chk_i (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .bus_in(bus_in), .rdata_out(rdata_out),
  .external_trigger_input_in(external_trigger_input_in),
  .t1_overflow_in(t1_overflow_in), .serial_mode_in(serial_mode_in),
  .rx_baud_tick_out(rx_baud_tick_out),
  .tx_baud_tick_out(tx_baud_tick_out),
  .timer_req_out(timer_req_out), .irq_out(irq_out));
